// >>> vdc_ctrl.sv
// module: device-side control of a virtual i/o device
//
// What the document requires
// [R1] offered features never include one whose dependency is not offered
// [R2] valid driver subsets accepted; rejected subsets leave features-ok clear
// [R3] a set once accepted is accepted again after a reset request, and after i_rst_n through the subset check
// [R4] driver picks only offered features with their dependencies
// [R5] driver falls back or sets failed on a missing understood feature
// [R6] driver not acknowledging version-1 is treated as legacy
// [R7] config and used notices go out; available notices come in per queue
// [R8] a reset request returns the status field to zero
// [R9] after reset, no notices and no queue access until reinitialised
// [R10] driver sees reset done when status reads zero
// [R11] multi-byte config fields are stored little-endian
// [R12] generation count changes whenever config contents may change
// [R13] driver re-reads until generation is stable
// [R14] driver checks offered feature before optional config access
// [R15] config space readable before features-ok, optional fields included
// [R16] each used buffer reports the bytes written
// [R17] buffers may complete out of order; in-order offered only if true
// [R18] queue reset only with ring-reset negotiated; reset then re-enable
// [R19] a reset queue executes nothing and sends no notices
// [R20] queue reset returns all queue state to defaults; the queue size keeps its value
// [R21] driver confirms queue reset before freeing its resources
// [R22] re-enable applies queue configuration changed meanwhile
// [R23] status bits: ack 1, driver 2, driver-ok 4, features-ok 8, 64, 128
// [R24] no buffer use or used notice before driver-ok
// [R25] offered set read-only; driver set writable only before features-ok
`timescale 1ns/10ps
module vdc_ctrl #(
  parameter logic [vdc_pkg::FEAT_W-1:0] DEV_FEAT   = 64'h0000_0101_0000_0003,
  parameter logic                       IN_ORDER_HW = 1'b0
) (
  input  wire logic                          i_core_clk,
  input  wire logic                          i_rst_n,
  input  wire logic                          i_ce,
  input  wire vdc_pkg::vdc_bus_s             i_bus,
  output logic [vdc_pkg::DATA_W-1:0]         o_rdata,
  input  wire logic                          i_cfg_wr,
  input  wire logic [1:0]                    i_cfg_idx,
  input  wire logic [vdc_pkg::DATA_W-1:0]    i_cfg_data,
  input  wire logic                          i_dev_err,
  input  wire logic                          i_done,
  input  wire logic [vdc_pkg::QIDX_W-1:0]    i_done_q,
  input  wire logic [vdc_pkg::LEN_W-1:0]     i_done_len,
  output vdc_pkg::vdc_used_s                 o_used,
  output logic                               o_cfg_ntf,
  output logic [vdc_pkg::NQ-1:0]             o_q_pend,
  output logic                               o_drv_ok,
  output logic                               o_legacy
);

  // ****************************************
  // offered feature set
  // ****************************************
  logic [vdc_pkg::FEAT_W-1:0] offer;
  always_comb begin
    offer = DEV_FEAT;
    offer[vdc_pkg::F_IN_ORDER] = IN_ORDER_HW; // [R17]
    // dependent feature dropped when its base is absent
    if (!offer[vdc_pkg::F_DEV_OPT]) begin
      offer[vdc_pkg::F_DEV_DEP] = 1'b0; // [R1]
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  logic [7:0]                 status_r;
  logic [7:0]                 status_nxt;
  logic [vdc_pkg::FEAT_W-1:0] drv_feat_r;
  logic [vdc_pkg::FEAT_W-1:0] drv_feat_nxt;
  logic [vdc_pkg::FEAT_W-1:0] good_feat_r;
  logic [vdc_pkg::FEAT_W-1:0] good_feat_nxt;
  logic                       good_vld_r;
  logic                       good_vld_nxt;
  logic [31:0]                gen_r;
  logic [31:0]                gen_nxt;
  logic [vdc_pkg::QIDX_W-1:0] qsel_r;
  logic [vdc_pkg::QIDX_W-1:0] qsel_nxt;
  logic [vdc_pkg::DATA_W-1:0] cfg_r [vdc_pkg::CFG_WORDS];
  logic [vdc_pkg::DATA_W-1:0] cfg_nxt [vdc_pkg::CFG_WORDS];
  logic                       cfg_ntf_r;
  logic                       cfg_ntf_nxt;
  logic [vdc_pkg::DATA_W-1:0] rdata_r;
  logic [vdc_pkg::DATA_W-1:0] rdata_nxt;

  logic wr_st;
  logic wr_rst;
  logic dev_rst;
  logic subset_ok;
  logic fok_req;
  logic fok_set;
  logic dok;
  logic ring_rst_ok;

  assign wr_st   = i_bus.wr && (i_bus.addr == vdc_pkg::A_STATUS);
  assign wr_rst  = i_bus.wr && (i_bus.addr == vdc_pkg::A_RESET);
  // writing zero to status, or any write to the reset register, is a reset request
  assign dev_rst = wr_rst || (wr_st && (i_bus.wdata[7:0] == 8'h00));

  // accept any subset of the offer whose dependencies are present
  assign subset_ok = ((drv_feat_r & ~offer) == '0) &&
                     !(drv_feat_r[vdc_pkg::F_DEV_DEP] &&
                       !drv_feat_r[vdc_pkg::F_DEV_OPT]); // [R2]
  assign fok_req = wr_st && i_bus.wdata[vdc_pkg::ST_FOK_BIT] &&
                   !status_r[vdc_pkg::ST_FOK_BIT];
  assign fok_set = fok_req &&
                   (subset_ok ||
                    (good_vld_r && (drv_feat_r == good_feat_r))); // [R2] [R3]
  assign dok     = status_r[vdc_pkg::ST_DOK_BIT] &&
                   !status_r[vdc_pkg::ST_FAIL_BIT];
  assign ring_rst_ok = status_r[vdc_pkg::ST_FOK_BIT] &&
                       drv_feat_r[vdc_pkg::F_RING_RESET]; // [R18]

  always_comb begin
    status_nxt    = status_r;
    drv_feat_nxt  = drv_feat_r;
    good_feat_nxt = good_feat_r;
    good_vld_nxt  = good_vld_r;
    qsel_nxt      = qsel_r;
    cfg_ntf_nxt   = 1'b0;
    gen_nxt       = gen_r;
    if (wr_st) begin
      status_nxt = status_r | (i_bus.wdata[7:0] & vdc_pkg::ST_DRV_MASK);
      status_nxt[vdc_pkg::ST_FOK_BIT] = status_r[vdc_pkg::ST_FOK_BIT] ||
                                        fok_set; // [R2] [R23]
    end
    if (fok_set) begin
      good_feat_nxt = drv_feat_r; // [R3]
      good_vld_nxt  = 1'b1;
    end
    if (!status_r[vdc_pkg::ST_FOK_BIT] && i_bus.wr) begin
      if (i_bus.addr == vdc_pkg::A_DRV_FEAT_LO) begin
        drv_feat_nxt[31:0] = i_bus.wdata; // [R25]
      end
      if (i_bus.addr == vdc_pkg::A_DRV_FEAT_HI) begin
        drv_feat_nxt[63:32] = i_bus.wdata; // [R25]
      end
    end
    if (i_bus.wr && (i_bus.addr == vdc_pkg::A_Q_SEL)) begin
      qsel_nxt = i_bus.wdata[vdc_pkg::QIDX_W-1:0];
    end
    if (i_cfg_wr) begin
      gen_nxt = gen_r + 32'h0000_0001; // [R12]
      cfg_ntf_nxt = dok; // [R7]
    end
    if (i_dev_err && !status_r[vdc_pkg::ST_NRS_BIT]) begin
      status_nxt[vdc_pkg::ST_NRS_BIT] = 1'b1; // [R23]
      cfg_ntf_nxt = dok;
    end
    if (dev_rst) begin
      status_nxt   = vdc_pkg::ST_RESET; // [R8]
      drv_feat_nxt = vdc_pkg::FEAT_RESET;
      qsel_nxt     = '0;
      cfg_ntf_nxt  = 1'b0; // [R9]
    end
  end

  // ****************************************
  // register read mux
  // ****************************************
  vdc_pkg::vdc_q_s q_st [vdc_pkg::NQ];
  always_comb begin
    rdata_nxt = '0;
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        vdc_pkg::A_DEV_FEAT_LO: rdata_nxt = offer[31:0]; // [R25]
        vdc_pkg::A_DEV_FEAT_HI: rdata_nxt = offer[63:32];
        vdc_pkg::A_DRV_FEAT_LO: rdata_nxt = drv_feat_r[31:0];
        vdc_pkg::A_DRV_FEAT_HI: rdata_nxt = drv_feat_r[63:32];
        vdc_pkg::A_STATUS:      rdata_nxt = {24'h00_0000, status_r}; // [R10]
        vdc_pkg::A_GEN:         rdata_nxt = gen_r;
        vdc_pkg::A_Q_SIZE: rdata_nxt = {16'h0000, q_st[qsel_r].size};
        vdc_pkg::A_Q_CTRL: rdata_nxt = {31'h0000_0000, q_st[qsel_r].en};
        vdc_pkg::A_Q_USEDLEN:   rdata_nxt = q_st[qsel_r].last_len;
        vdc_pkg::A_LEGACY:      rdata_nxt = {31'h0000_0000, o_legacy};
        default: begin
          // config words served whatever the negotiation state
          if (i_bus.addr[7:4] == vdc_pkg::A_CFG_BASE[7:4]) begin
            rdata_nxt = cfg_r[i_bus.addr[3:2]]; // [R15] [R11]
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status_r    <= vdc_pkg::ST_RESET;
      drv_feat_r  <= vdc_pkg::FEAT_RESET;
      good_feat_r <= vdc_pkg::FEAT_RESET;
      good_vld_r  <= 1'b0;
      gen_r       <= 32'h0000_0000;
      qsel_r      <= '0;
      cfg_ntf_r   <= 1'b0;
    end else if (i_ce) begin
      status_r    <= status_nxt;
      drv_feat_r  <= drv_feat_nxt;
      good_feat_r <= good_feat_nxt;
      good_vld_r  <= good_vld_nxt;
      gen_r       <= gen_nxt;
      qsel_r      <= qsel_nxt;
      cfg_ntf_r   <= cfg_ntf_nxt;
    end
  end

  // read data stands one cycle and is zero otherwise
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (i_ce) begin
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // device-specific config words
  // ****************************************
  // device side owns these; the driver only reads them
  always_comb begin
    cfg_nxt = cfg_r;
    if (i_cfg_wr) begin
      cfg_nxt[i_cfg_idx] = i_cfg_data; // [R11]
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < vdc_pkg::CFG_WORDS; i++) begin
        cfg_r[i] <= 32'h0000_0000;
      end
    end else if (i_ce) begin
      cfg_r <= cfg_nxt;
    end
  end

  // ****************************************
  // queues
  // ****************************************
  logic [vdc_pkg::NQ-1:0] q_ntf;
  logic                   wr_qctrl;
  logic                   wr_ntf;
  assign wr_qctrl = i_bus.wr && (i_bus.addr == vdc_pkg::A_Q_CTRL);
  assign wr_ntf   = i_bus.wr && (i_bus.addr == vdc_pkg::A_Q_NOTIFY);

  genvar g;
  generate
    for (g = 0; g < vdc_pkg::NQ; g++) begin : g_q
      logic sel;
      assign sel = (qsel_r == g[vdc_pkg::QIDX_W-1:0]);
      vdc_queue u_q (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_ce       (i_ce),
        .i_dev_rst  (dev_rst),
        .i_q_rst    (wr_qctrl && sel && ring_rst_ok &&
                     i_bus.wdata[vdc_pkg::Q_CTRL_RST_BIT]), // [R18]
        .i_q_en     (wr_qctrl && sel &&
                     i_bus.wdata[vdc_pkg::Q_CTRL_EN_BIT]),
        .i_size_wr  (i_bus.wr && sel && (i_bus.addr == vdc_pkg::A_Q_SIZE)),
        .i_size     (i_bus.wdata[vdc_pkg::QSZ_W-1:0]),
        .i_avail    (wr_ntf && (i_bus.wdata[vdc_pkg::QIDX_W-1:0] ==
                                g[vdc_pkg::QIDX_W-1:0])), // [R7]
        .i_run_ok   (dok), // [R24] [R9]
        .i_done     (i_done && (i_done_q == g[vdc_pkg::QIDX_W-1:0])),
        .i_done_len (i_done_len),
        .o_q        (q_st[g]),
        .o_used_ntf (q_ntf[g]),
        .o_pend     (o_q_pend[g])
      );
    end
  endgenerate

  // ****************************************
  // outputs
  // ****************************************
  logic [vdc_pkg::QIDX_W-1:0] nq;
  always_comb begin
    nq = '0;
    for (int i = vdc_pkg::NQ - 1; i >= 0; i--) begin
      if (q_ntf[i]) begin
        nq = i[vdc_pkg::QIDX_W-1:0];
      end
    end
  end

  assign o_used   = '{valid: |q_ntf, qidx: nq, len: q_st[nq].last_len}; // [R16]
  assign o_cfg_ntf = cfg_ntf_r;
  assign o_rdata  = rdata_r;
  assign o_drv_ok = dok;
  // legacy when version-1 is not acked; before features-ok only a
  // driver that has announced itself is judged
  always_comb begin
    o_legacy = !drv_feat_r[vdc_pkg::F_VERSION_1]; // [R6]
    if (!status_r[vdc_pkg::ST_FOK_BIT] &&
        !status_r[vdc_pkg::ST_DRV_BIT]) begin
      o_legacy = 1'b0;
    end
  end

endmodule // vdc_ctrl

// >>> vdc_ctrl_assertions.sv
// checker: concurrent checks on the device control block ports
`timescale 1ns/10ps
module vdc_ctrl_assertions (
  input  wire logic                          i_core_clk,
  input  wire logic                          i_rst_n,
  input  wire logic                          i_ce,
  input  wire vdc_pkg::vdc_bus_s             i_bus,
  input  wire logic [vdc_pkg::DATA_W-1:0]    o_rdata,
  input  wire logic                          i_cfg_wr,
  input  wire logic                          i_dev_err,
  input  wire logic                          i_done,
  input  wire logic [vdc_pkg::QIDX_W-1:0]    i_done_q,
  input  wire logic [vdc_pkg::LEN_W-1:0]     i_done_len,
  input  wire vdc_pkg::vdc_used_s            o_used,
  input  wire logic                          o_cfg_ntf,
  input  wire logic [vdc_pkg::NQ-1:0]        o_q_pend,
  input  wire logic                          o_drv_ok,
  input  wire logic                          o_legacy
);
  // ****************************************
  // port checks
  // ****************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // decoded once so $past sees plain signals, except i_bus.wr in p_leg
  wire st_wr  = i_ce && i_bus.wr && i_bus.addr == vdc_pkg::A_STATUS;
  wire rs_wr  = i_ce && i_bus.wr && i_bus.addr == vdc_pkg::A_RESET;
  wire dok_wr = st_wr && i_bus.wdata[vdc_pkg::ST_DOK_BIT];
  wire rd_t   = i_ce && i_bus.rd;
  wire n_src  = i_cfg_wr || i_dev_err;
  property p_rst;
    rs_wr |=> !o_drv_ok && o_q_pend == '0;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset write left driver-ok or queue work");
  property p_dok;
    $rose(o_drv_ok) |-> $past(dok_wr);
  endproperty
  a_dok: assert property (p_dok)
    else $error("driver-ok rose without a status write");
  property p_fail;
    st_wr && i_bus.wdata[vdc_pkg::ST_FAIL_BIT] |=> !o_drv_ok;
  endproperty
  a_fail: assert property (p_fail)
    else $error("failed bit did not drop driver-ok");
  property p_used_dok;
    o_used.valid |-> $past(o_drv_ok);
  endproperty
  a_used_dok: assert property (p_used_dok)
    else $error("used notice before driver-ok");
  property p_used_src;
    o_used.valid |-> $past(i_done) && o_used.len == $past(i_done_len)
      && o_used.qidx == $past(i_done_q);
  endproperty
  a_used_src: assert property (p_used_src)
    else $error("used notice does not match the completion");
  property p_ntf;
    i_ce && i_cfg_wr && o_drv_ok |=> o_cfg_ntf;
  endproperty
  a_ntf: assert property (p_ntf)
    else $error("config change sent no notice");
  property p_ntf_src;
    o_cfg_ntf |-> $past(n_src);
  endproperty
  a_ntf_src: assert property (p_ntf_src)
    else $error("config notice without a cause");
  property p_ntf_dok;
    o_cfg_ntf |-> $past(o_drv_ok);
  endproperty
  a_ntf_dok: assert property (p_ntf_dok)
    else $error("config notice while not driver-ok");
  property p_rd_idle;
    !$past(rd_t) |-> o_rdata == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside the answer cycle");
  property p_leg;
    $changed(o_legacy) |-> $past(i_bus.wr) || i_bus.wr;
  endproperty
  a_leg: assert property (p_leg)
    else $error("legacy flag moved without a write");
endmodule // vdc_ctrl_assertions

bind vdc_ctrl vdc_ctrl_assertions u_chk (
  .i_core_clk, .i_rst_n, .i_ce, .i_bus, .o_rdata, .i_cfg_wr,
  .i_dev_err, .i_done, .i_done_q, .i_done_len, .o_used, .o_cfg_ntf,
  .o_q_pend, .o_drv_ok, .o_legacy
);

// >>> vdc_drv.sv
// model: guest driver as bus master of the device control block
`timescale 1ns/10ps
module vdc_drv (
  input  wire logic         i_core_clk,
  output vdc_pkg::vdc_bus_s o_bus
);
  // ****************************************
  // bus cycles
  // ****************************************
  initial o_bus = '0;
  // idle lines carry the inverse so stale values never look valid
  task automatic cyc(input logic [7:0] a, input logic [31:0] d,
                     input logic wr);
    o_bus <= '{addr: a, wdata: d, wr: wr, rd: !wr};
    @(posedge i_core_clk);
    o_bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    @(posedge i_core_clk);
  endtask
endmodule // vdc_drv

// >>> vdc_pkg.sv
// package: constants and carriers for the virtual device control block
package vdc_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int unsigned FEAT_W  = 64;
  localparam int unsigned NQ      = 4;
  localparam int unsigned QIDX_W  = 2;
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned QSZ_W   = 16;
  localparam int unsigned LEN_W   = 32;

  // ****************************************
  // status bits
  // ****************************************
  localparam int unsigned ST_ACK_BIT  = 0;
  localparam int unsigned ST_DRV_BIT  = 1;
  localparam int unsigned ST_DOK_BIT  = 2;
  localparam int unsigned ST_FOK_BIT  = 3;
  localparam int unsigned ST_NRS_BIT  = 6;
  localparam int unsigned ST_FAIL_BIT = 7;
  localparam logic [7:0]  ST_RESET    = 8'h00;
  localparam logic [7:0]  ST_DRV_MASK = 8'h8f;

  // ****************************************
  // feature bits
  // ****************************************
  localparam int unsigned F_IN_ORDER   = 35;
  localparam int unsigned F_VERSION_1  = 32;
  localparam int unsigned F_RING_RESET = 40;
  localparam int unsigned F_DEV_OPT    = 0;
  localparam int unsigned F_DEV_DEP    = 1;
  localparam logic [FEAT_W-1:0] FEAT_RESET = 64'h0000_0000_0000_0000;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] A_DEV_FEAT_LO = 8'h00;
  localparam logic [ADDR_W-1:0] A_DEV_FEAT_HI = 8'h04;
  localparam logic [ADDR_W-1:0] A_DRV_FEAT_LO = 8'h08;
  localparam logic [ADDR_W-1:0] A_DRV_FEAT_HI = 8'h0c;
  localparam logic [ADDR_W-1:0] A_STATUS      = 8'h10;
  localparam logic [ADDR_W-1:0] A_RESET       = 8'h14;
  localparam logic [ADDR_W-1:0] A_GEN         = 8'h18;
  localparam logic [ADDR_W-1:0] A_Q_SEL       = 8'h1c;
  localparam logic [ADDR_W-1:0] A_Q_SIZE      = 8'h20;
  localparam logic [ADDR_W-1:0] A_Q_CTRL      = 8'h24;
  localparam logic [ADDR_W-1:0] A_Q_NOTIFY    = 8'h28;
  localparam logic [ADDR_W-1:0] A_Q_USEDLEN   = 8'h2c;
  localparam logic [ADDR_W-1:0] A_LEGACY      = 8'h30;
  localparam logic [ADDR_W-1:0] A_CFG_BASE    = 8'h40;
  localparam int unsigned       CFG_WORDS     = 4;
  localparam logic [QSZ_W-1:0]  QSZ_RESET     = 16'h0100;
  localparam int unsigned Q_CTRL_EN_BIT  = 0;
  localparam int unsigned Q_CTRL_RST_BIT = 1;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } vdc_bus_s;

  typedef struct packed {
    logic              valid;
    logic [QIDX_W-1:0] qidx;
    logic [LEN_W-1:0]  len;
  } vdc_used_s;

  typedef struct packed {
    logic              en;
    logic [QSZ_W-1:0]  size;
    logic [15:0]       avail_idx;
    logic [15:0]       used_idx;
    logic [LEN_W-1:0]  last_len;
  } vdc_q_s;

  typedef enum logic [1:0] {
    VDC_Q_IDLE,
    VDC_Q_RUN,
    VDC_Q_RESET
  } vdc_qst_e;

endpackage

// >>> vdc_queue.sv
// module: per-queue state, reset and re-enable of one virtqueue
`timescale 1ns/10ps
module vdc_queue (
  input  wire logic                       i_core_clk,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_ce,
  input  wire logic                       i_dev_rst,
  input  wire logic                       i_q_rst,
  input  wire logic                       i_q_en,
  input  wire logic                       i_size_wr,
  input  wire logic [vdc_pkg::QSZ_W-1:0]  i_size,
  input  wire logic                       i_avail,
  input  wire logic                       i_run_ok,
  input  wire logic                       i_done,
  input  wire logic [vdc_pkg::LEN_W-1:0]  i_done_len,
  output vdc_pkg::vdc_q_s                 o_q,
  output logic                            o_used_ntf,
  output logic                            o_pend
);

  // ****************************************
  // state
  // ****************************************
  vdc_pkg::vdc_qst_e st_r;
  vdc_pkg::vdc_qst_e st_nxt;
  vdc_pkg::vdc_q_s   q_r;
  vdc_pkg::vdc_q_s   q_nxt;
  logic              ntf_r;
  logic              ntf_nxt;
  logic              active;

  assign active = (st_r == vdc_pkg::VDC_Q_RUN) && i_run_ok;

  always_comb begin
    st_nxt  = st_r;
    q_nxt   = q_r;
    ntf_nxt = 1'b0;
    if (i_size_wr && (st_r != vdc_pkg::VDC_Q_RUN)) begin
      q_nxt.size = i_size; // [R22]
    end
    if (active && i_avail) begin
      q_nxt.avail_idx = q_r.avail_idx + 16'h0001;
    end
    // a completion is only taken while work is outstanding
    if (active && i_done && (q_r.used_idx != q_r.avail_idx)) begin
      q_nxt.used_idx = q_r.used_idx + 16'h0001;
      q_nxt.last_len = i_done_len; // [R16]
      ntf_nxt        = 1'b1; // [R7] [R24]
    end
    unique case (st_r)
      vdc_pkg::VDC_Q_IDLE: begin
        if (i_q_en) begin
          st_nxt = vdc_pkg::VDC_Q_RUN; // [R22]
        end
      end
      vdc_pkg::VDC_Q_RUN: begin
        if (i_q_rst) begin
          st_nxt = vdc_pkg::VDC_Q_RESET; // [R18] [R19]
        end
      end
      vdc_pkg::VDC_Q_RESET: begin
        if (i_q_en) begin
          st_nxt = vdc_pkg::VDC_Q_RUN; // [R18]
        end
      end
    endcase
    if (i_q_rst) begin
      q_nxt.avail_idx = 16'h0000; // [R20]
      q_nxt.used_idx  = 16'h0000; // [R20]
      q_nxt.last_len  = '0; // [R20]
      ntf_nxt         = 1'b0; // [R19]
    end
    if (i_dev_rst) begin
      st_nxt  = vdc_pkg::VDC_Q_IDLE;
      q_nxt   = '0;
      q_nxt.size = vdc_pkg::QSZ_RESET;
      ntf_nxt = 1'b0; // [R9]
    end
    q_nxt.en = (st_nxt == vdc_pkg::VDC_Q_RUN);
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r  <= vdc_pkg::VDC_Q_IDLE;
      q_r   <= '{en: 1'b0, size: vdc_pkg::QSZ_RESET, avail_idx: 16'h0000,
                 used_idx: 16'h0000, last_len: 32'h0000_0000};
      ntf_r <= 1'b0;
    end else if (i_ce) begin
      st_r  <= st_nxt;
      q_r   <= q_nxt;
      ntf_r <= ntf_nxt;
    end
  end

  assign o_q        = q_r;
  assign o_used_ntf = ntf_r;
  assign o_pend     = active && (q_r.used_idx != q_r.avail_idx); // [R19]

endmodule // vdc_queue

// >>> virtio_device_control_tb.sv
// bench: self-checking test of the virtual device control block
`timescale 1ns/10ps
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("wrong value at %0t: got %h want %h", $time, g, e); \
  end \
end
module virtio_device_control_tb;
  // ****************************************
  // stimulus and checking
  // ****************************************
  logic              clk, rst_n, ce, cfg_wr, dev_err, done, cfg_ntf;
  logic              drv_ok, legacy, rd_d;
  logic [1:0]        cfg_idx, done_q;
  logic [3:0]        pend;
  logic [31:0]       cfg_data, done_len, rdata, seed, v, er;
  logic [33:0]       eu;
  logic [63:0]       bad [3];
  vdc_pkg::vdc_bus_s  bus;
  vdc_pkg::vdc_used_s used;
  int                miscompares, samples_checked;
  logic [31:0]       rd_q [$];
  logic [33:0]       used_q [$];

  vdc_ctrl DUT (.i_core_clk(clk), .i_rst_n(rst_n), .i_ce(ce),
    .i_bus(bus), .o_rdata(rdata), .i_cfg_wr(cfg_wr),
    .i_cfg_idx(cfg_idx), .i_cfg_data(cfg_data), .i_dev_err(dev_err),
    .i_done(done), .i_done_q(done_q), .i_done_len(done_len),
    .o_used(used), .o_cfg_ntf(cfg_ntf), .o_q_pend(pend),
    .o_drv_ok(drv_ok), .o_legacy(legacy));
  vdc_drv drv (.i_core_clk(clk), .o_bus(bus));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    drv.cyc(a, d, 1'b1);
  endtask
  task automatic r(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    drv.cyc(a, ~e, 1'b0);
  endtask
  // driver sets are sent to see them accepted or refused, invalid ones on purpose
  task automatic neg(input logic [31:0] lo, hi, st);
    w(8'h10, 32'h0000_0003);
    w(8'h08, lo);
    w(8'h0c, hi);
    w(8'h10, 32'h0000_0008);
    r(8'h10, st);
  endtask
  task automatic fin(input logic [1:0] q, input logic ok);
    v = xs();
    if (ok) used_q.push_back({q, v});
    done <= 1'b1;
    done_q <= q;
    done_len <= v;
    @(posedge clk);
    done <= 1'b0;
    @(posedge clk);
  endtask
  task automatic cfg(input logic [1:0] k, input logic n);
    v = xs();
    cfg_wr <= 1'b1;
    cfg_idx <= k;
    cfg_data <= v;
    @(posedge clk);
    cfg_wr <= 1'b0;
    @(negedge clk);
    `CHK(cfg_ntf, n)
    @(posedge clk);
  endtask
  task automatic results();
    miscompares += rd_q.size() + used_q.size();
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // a missing expectation is forced to mismatch
  always @(posedge clk) rd_d <= bus.rd;
  always @(negedge clk) begin
    if (rd_d === 1'b1) begin
      if (rd_q.size() == 0) rd_q.push_back(~rdata);
      er = rd_q.pop_front();
      `CHK(rdata, er)
    end
    if (used.valid !== 1'b0) begin
      if (used_q.size() == 0) used_q.push_back(~{used.qidx, used.len});
      eu = used_q.pop_front();
      `CHK({used.qidx, used.len}, eu)
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    results();
  end

  initial begin
    seed = 32'h6de7_0b54;
    {rst_n, cfg_wr, dev_err, done} = 4'h0;
    ce = 1'b1;
    {cfg_idx, done_q, cfg_data, done_len} = '0;
    bad = '{64'h0000_0101_0000_0002, 64'h0000_0101_0000_0007,
            64'h0000_0002_0000_0001};
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    r(8'h10, 32'h0000_0000);
    r(8'h00, 32'h0000_0003);
    r(8'h04, 32'h0000_0101);
    w(8'h00, xs());
    r(8'h00, 32'h0000_0003);
    r(8'h20, 32'h0000_0100);
    for (int k = 0; k < 4; k++) begin
      cfg(k[1:0], 1'b0);
      r(8'h40 + 8'(4 * k), v);
    end
    r(8'h18, 32'h0000_0004);
    r(8'h4c, v);
    r(8'h18, 32'h0000_0004);
    for (int k = 0; k < 3; k++) begin
      neg(bad[k][31:0], bad[k][63:32], 32'h0000_0003);
      w(8'h14, 32'h0000_0000);
      r(8'h10, 32'h0000_0000);
    end
    neg(32'h0000_0003, 32'h0000_0000, 32'h0000_000b);
    r(8'h30, 32'h0000_0001);
    `CHK(legacy, 1'b1)
    w(8'h10, 32'h0000_0000);
    neg(32'h0000_0003, 32'h0000_0101, 32'h0000_000b);
    r(8'h30, 32'h0000_0000);
    `CHK(legacy, 1'b0)
    w(8'h08, 32'h0000_0000);
    r(8'h08, 32'h0000_0003);
    w(8'h1c, 32'h0000_0000);
    w(8'h24, 32'h0000_0001);
    w(8'h28, 32'h0000_0000);
    fin(2'd0, 1'b0);
    w(8'h10, 32'h0000_0004);
    r(8'h10, 32'h0000_000f);
    `CHK(drv_ok, 1'b1)
    cfg(2'd1, 1'b1);
    w(8'h28, 32'h0000_0000);
    fin(2'd0, 1'b1);
    r(8'h2c, v);
    fin(2'd0, 1'b0);
    w(8'h28, 32'h0000_0000);
    w(8'h28, 32'h0000_0001);
    `CHK(pend, 4'h1)
    w(8'h24, 32'h0000_0002);
    `CHK(pend, 4'h0)
    fin(2'd0, 1'b0);
    r(8'h2c, 32'h0000_0000);
    w(8'h20, 32'h0000_0040);
    w(8'h24, 32'h0000_0001);
    r(8'h20, 32'h0000_0040);
    w(8'h28, 32'h0000_0000);
    fin(2'd0, 1'b1);
    w(8'h14, 32'h0000_0000);
    r(8'h10, 32'h0000_0000);
    `CHK(drv_ok, 1'b0)
    fin(2'd0, 1'b0);
    cfg(2'd2, 1'b0);
    neg(32'h0000_0003, 32'h0000_0101, 32'h0000_000b);
    w(8'h10, 32'h0000_0004);
    w(8'h10, 32'h0000_0080);
    r(8'h10, 32'h0000_008f);
    `CHK(drv_ok, 1'b0)
    dev_err <= 1'b1;
    @(posedge clk);
    dev_err <= 1'b0;
    @(posedge clk);
    r(8'h10, 32'h0000_00cf);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    r(8'h10, 32'h0000_0000);
    // a write while the enable is low must leave status alone
    ce <= 1'b0;
    w(8'h10, 32'h0000_0001);
    ce <= 1'b1;
    r(8'h10, 32'h0000_0000);
    results();
  end
endmodule // virtio_device_control_tb
